// ---- shared/dst_map.svh ----
`ifndef DST_MAP_SVH
`define DST_MAP_SVH
// character framing
`define DST_CHAR_LAST   4'hA
`define DST_STX         8'h02
// telegram lengths and positions
`define DST_LGE_PCD     8'h06
`define DST_LGE_PAR     8'h0E
`define DST_LGE_TXT     8'h0A
`define DST_LGE_MAX     8'h1E
`define DST_PCD_SPAN    8'h03
`define DST_POS_LGE     5'h01
`define DST_POS_ADR     5'h02
`define DST_POS_PKE_H   6'h03
`define DST_POS_PKE_L   6'h04
`define DST_POS_IND_H   6'h05
`define DST_POS_IND_L   6'h06
`define DST_POS_PWE     6'h07
`define DST_POS_PWE_END 6'h0A
`define DST_POS_TXT     5'h07
`define DST_TXT_MAX     5'h14
// command codes toward the device
`define DST_CMD_NONE    4'h0
`define DST_CMD_READ    4'h1
`define DST_CMD_WR_W    4'h2
`define DST_CMD_WR_D    4'h3
`define DST_CMD_WR_DE   4'hD
`define DST_CMD_WR_WE   4'hE
`define DST_CMD_TEXT    4'hF
// response codes toward the master
`define DST_RSP_NONE    4'h0
`define DST_RSP_WORD    4'h1
`define DST_RSP_DWORD   4'h2
`define DST_RSP_FAIL    4'h7
`define DST_RSP_TEXT    4'hF
// fault reports in the low value word
`define DST_FLT_NO_PARAM 8'h00
`define DST_FLT_NO_WRITE 8'h01
`define DST_FLT_LIMIT    8'h02
`define DST_FLT_SUBIDX   8'h03
`define DST_FLT_NOT_ARR  8'h04
`define DST_FLT_TYPE     8'h05
`define DST_FLT_MODE     8'h0B
`define DST_FLT_NO_BUS   8'h52
`define DST_FLT_FACTORY  8'h53
// subscript high byte for text access
`define DST_TXT_RD      8'h04
`define DST_TXT_WR      8'h05
// data type codes
`define DST_DT_I16      8'h03
`define DST_DT_I32      8'h04
`define DST_DT_U8       8'h05
`define DST_DT_U16      8'h06
`define DST_DT_U32      8'h07
`define DST_DT_TEXT     8'h09
`define DST_DT_BYTES    8'h0A
`define DST_DT_TDIFF    8'h0D
`define DST_DT_BITS     8'h23
`endif

// ---- shared/dst_pkg.sv ----
package dst_pkg;
   typedef enum logic [2:0] {
      ST_RX    = 3'b000,
      ST_EXEC  = 3'b001,
      ST_COPY  = 3'b010,
      ST_BUILD = 3'b011,
      ST_TX    = 3'b100
   } dst_state_t;

   typedef struct packed {
      logic        rx_m;
      logic        rx_s;
      logic        rx_on;
      logic [15:0] rx_cnt;
      logic [3:0]  rx_bit;
      logic [8:0]  rx_sh;
      logic        tx_on;
      logic [15:0] tx_cnt;
      logic [3:0]  tx_bit;
      logic [10:0] tx_sh;
      logic        txd;
      logic        tx_oe;
      dst_state_t  st;
      logic [4:0]  idx;
      logic [7:0]  length_byte;
      logic [7:0]  xacc;
      logic        bad;
      logic [7:0]  adr;
      logic [15:0] param_id_word;
      logic [15:0] subscript_word;
      logic [31:0] param_value_block;
      logic [31:0] process_block;
      logic [3:0]  rsp;
      logic [31:0] rpwe;
      logic [7:0]  rlge;
      logic [4:0]  tn;
      logic [4:0]  cp;
      logic [4:0]  cpp;
      logic        pend;
      logic [5:0]  bidx;
      logic        preq;
      logic [15:0] ctrl;
      logic [15:0] refv;
      logic        pcd_stb;
      logic [4:0]  taddr;
      logic [7:0]  twdata;
      logic        twe;
      logic        tg_ok;
      logic        tg_drop;
   } dst_regs_t;
endpackage : dst_pkg

// ---- hw/dst_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module dst_buf (
   input  wire logic       ref_clk,
   input  wire logic       we,
   input  wire logic [4:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:31];

   // one port, read data registered
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : dst_buf
`default_nettype wire

// ---- hw/dst_slave.sv ----
// Summary of operation
// - start, eight data, parity, stop bits
// - parity makes ones count even
// - start char, length, address, data, check
// - length is data count plus two
// - text telegram length ten plus text
// - short address format, bit5 broadcast
// - long address format, zero broadcast
// - address byte echoed unchanged
// - check byte is running XOR
// - same layouts both directions
// - process block four bytes
// - parameter block twelve bytes with process
// - id bits 15..12 carry command/response
// - id bits 11..0 carry parameter number
// - decode listed command codes
// - return listed response codes
// - fault code in low value word
// - only subscript low byte indexes arrays
// - value block two words
// - text command F, subscript 4 read, 5 write
// - text read reply reports actual length, capped at 20
// - data type codes interpreted
// - values travel as integers only
// - transmit only after being addressed
// - even parity, one stop, settable rate
`timescale 1ns/1ps
`default_nettype none
`include "dst_map.svh"
module dst_slave (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  rxd,
   output logic                       txd,
   output logic                       txd_oe,
   input  wire logic [6:0]            node_addr,
   input  wire logic [15:0]           baud_div,
   output logic                       param_req,
   output logic [3:0]                 param_command_code,
   output logic [11:0]                param_number_field,
   output logic [7:0]                 param_sub,
   output logic [31:0]                param_wdata,
   input  wire logic                  param_ack,
   input  wire logic                  param_ok,
   input  wire logic [7:0]            param_fault,
   input  wire logic [31:0]           param_rdata,
   input  wire logic [7:0]            param_dtype,
   input  wire logic [4:0]            text_len,
   input  wire logic [7:0]            text_rdata,
   output logic [4:0]                 text_addr,
   output logic [7:0]                 text_wdata,
   output logic                       text_we,
   output logic [15:0]                ctrl_word,
   output logic [15:0]                ref_value,
   output logic                       pcd_stb,
   input  wire logic [15:0]           status_word,
   input  wire logic [15:0]           out_freq,
   output logic                       tg_ok,
   output logic                       tg_drop
);
   import dst_pkg::*;

   dst_regs_t  q;
   dst_regs_t  n;
   logic       b_we;
   logic [4:0] b_addr;
   logic [7:0] b_wd;
   logic [7:0] b_rd;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] s);
      byte_of = w[31 - 8 * s -: 8];   // high byte travels first
   endfunction : byte_of

   function automatic logic par_of(input logic [7:0] b);
      par_of = ^b;
   endfunction : par_of

   function automatic logic is_bcast(input logic [7:0] a);
      is_bcast = a[7] ? (a[6:0] == 7'h00) : a[5];
   endfunction : is_bcast

   function automatic logic is_me(input logic [7:0] a, input logic [6:0] node);
      if (a[7]) begin
         is_me = (a[6:0] == node) && (node != 7'h00);
      end else begin
         is_me = !a[5] && (a[4:0] == node[4:0]) && (node[6:5] == 2'b00) && (node != 7'h00);
      end
   endfunction : is_me

   function automatic logic is_wide(input logic [7:0] dt);
      is_wide = (dt == `DST_DT_I32) || (dt == `DST_DT_U32) || (dt == `DST_DT_TDIFF)
                || (dt == `DST_DT_BITS);
   endfunction : is_wide

   ////////////////////////////////////////////////////////////////////////////
   dst_buf u_buf (
      .ref_clk (ref_clk),
      .we      (b_we),
      .addr    (b_addr),
      .wdata   (b_wd),
      .rdata   (b_rd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // all next-state logic
   always_comb begin
      logic       rx_done;
      logic [7:0] rx_b;
      logic       rx_err;
      logic [7:0] rbyte;
      logic [5:0] off;
      logic [7:0] pos;
      rx_done = 1'b0;
      rx_b    = q.rx_sh[7:0];
      rx_err  = 1'b0;
      rbyte   = 8'h00;
      off     = 6'h00;
      pos     = {3'b000, q.idx};
      n       = q;
      b_we    = 1'b0;
      b_addr  = 5'h00;
      b_wd    = 8'h00;
      n.preq    = 1'b0;
      n.pcd_stb = 1'b0;
      n.twe     = 1'b0;
      n.tg_ok   = 1'b0;
      n.tg_drop = 1'b0;

      // pin synchroniser, only rx_s is looked at
      n.rx_m = rxd;
      n.rx_s = q.rx_m;

      if (!q.rx_on) begin
         if (!q.rx_s) begin
            n.rx_on  = 1'b1;
            n.rx_cnt = {1'b0, baud_div[15:1]};
            n.rx_bit = 4'h0;
         end
      end else if (q.rx_cnt != 16'h0000) begin
         n.rx_cnt = q.rx_cnt - 16'h0001;
      end else begin
         n.rx_cnt = baud_div - 16'h0001;
         n.rx_bit = q.rx_bit + 4'h1;
         if (q.rx_bit == 4'h0) begin
            n.rx_on = !q.rx_s;          // glitch, not a start bit
         end else if (q.rx_bit == `DST_CHAR_LAST) begin
            // stop bit closes eleven bit times
            n.rx_on = 1'b0;
            rx_done = 1'b1;
            // even parity over data and parity
            rx_err  = par_of(q.rx_sh[7:0]) ^ q.rx_sh[8] | !q.rx_s;
         end else begin
            n.rx_sh = {q.rx_s, q.rx_sh[8:1]};
         end
      end

      // transmitter, a bit shifted out per bit time
      if (q.tx_on) begin
         if (q.tx_cnt != 16'h0000) begin
            n.tx_cnt = q.tx_cnt - 16'h0001;
         end else begin
            n.tx_cnt = baud_div - 16'h0001;
            n.tx_bit = q.tx_bit + 4'h1;
            if (q.tx_bit == `DST_CHAR_LAST) begin
               n.tx_on = 1'b0;
            end else begin
               n.tx_sh = {1'b1, q.tx_sh[10:1]};
               n.txd   = q.tx_sh[1];
            end
         end
      end

      case (q.st)
         ST_RX: begin
            if (rx_done) begin
               // telegram must open with start char
               if (q.idx == 5'h00) begin
                  if (rx_b == `DST_STX && !rx_err) begin
                     n.idx  = 5'h01;
                     n.xacc = 8'h00 ^ rx_b;
                     n.bad  = 1'b0;
                     n.process_block  = 32'h0000_0000;
                  end
               end else begin
                  b_we   = 1'b1;
                  b_addr = q.idx;
                  b_wd   = rx_b;
                  n.xacc = q.xacc ^ rx_b;
                  n.bad  = q.bad | rx_err;
                  n.idx  = q.idx + 5'h01;
                  // length must fit, data plus two
                  if (q.idx == `DST_POS_LGE) begin
                     n.length_byte = rx_b;
                     if (rx_b < `DST_LGE_PCD || rx_b > `DST_LGE_MAX) begin
                        n.idx = 5'h00;
                     end
                  end
                  if (q.idx == `DST_POS_ADR) begin
                     n.adr = rx_b;
                  end
                  // parameter fields ahead of process block
                  if (q.length_byte != `DST_LGE_PCD) begin
                     if (pos[5:0] == `DST_POS_PKE_H || pos[5:0] == `DST_POS_PKE_L) begin
                        n.param_id_word = {q.param_id_word[7:0], rx_b};
                     end
                     if (pos[5:0] == `DST_POS_IND_H || pos[5:0] == `DST_POS_IND_L) begin
                        n.subscript_word = {q.subscript_word[7:0], rx_b};
                     end
                  end
                  if (q.length_byte == `DST_LGE_PAR && pos[5:0] >= `DST_POS_PWE
                      && pos[5:0] <= `DST_POS_PWE_END) begin
                     n.param_value_block = {q.param_value_block[23:0], rx_b};
                  end
                  // process block is last four data bytes
                  if (pos >= q.length_byte - `DST_PCD_SPAN && pos <= q.length_byte) begin
                     n.process_block = {q.process_block[23:0], rx_b};
                  end
                  // the length of a past telegram must not end this one early
                  if (q.idx > `DST_POS_ADR && pos == q.length_byte + 8'h01) begin
                     n.idx = 5'h00;
                     if (q.bad || rx_err || (q.xacc ^ rx_b) != 8'h00) begin
                        n.tg_drop = 1'b1;
                     end else if (is_bcast(q.adr)) begin
                        // broadcast, short format via bit 5 or long format address zero
                        n.ctrl    = q.process_block[31:16];
                        n.refv    = q.process_block[15:0];
                        n.pcd_stb = 1'b1;
                        n.tg_ok   = 1'b1;
                     end else if (is_me(q.adr, node_addr)) begin
                        n.ctrl    = q.process_block[31:16];
                        n.refv    = q.process_block[15:0];
                        n.pcd_stb = 1'b1;
                        n.tg_ok   = 1'b1;
                        n.pend    = 1'b0;
                        n.st      = ST_EXEC;
                     end else begin
                        n.tg_drop = 1'b1;
                     end
                  end
               end
            end
         end

         ST_EXEC: begin
            n.rlge = q.length_byte;
            n.tn   = 5'h00;
            n.cp   = 5'h00;
            n.bidx = 6'h00;
            if (!q.pend) begin
               n.rpwe = 32'h0000_0000;
               if (q.length_byte == `DST_LGE_PCD || q.param_id_word[15:12] == `DST_CMD_NONE) begin
                  n.rsp = `DST_RSP_NONE;
                  n.st  = ST_BUILD;
               end else begin
                  case (q.param_id_word[15:12])
                     `DST_CMD_READ, `DST_CMD_WR_W, `DST_CMD_WR_D,
                     `DST_CMD_WR_DE, `DST_CMD_WR_WE: begin
                        n.preq = 1'b1;
                        n.pend = 1'b1;
                     end
                     `DST_CMD_TEXT: begin
                        if (q.subscript_word[15:8] == `DST_TXT_RD || q.subscript_word[15:8] == `DST_TXT_WR) begin
                           n.preq = 1'b1;
                           n.pend = 1'b1;
                        end else begin
                           n.rsp  = `DST_RSP_FAIL;
                           n.rpwe = {24'h000000, `DST_FLT_SUBIDX};
                           n.st   = ST_BUILD;
                        end
                     end
                     default: begin
                        n.rsp  = `DST_RSP_FAIL;
                        n.rpwe = {24'h000000, `DST_FLT_NO_PARAM};
                        n.st   = ST_BUILD;
                     end
                  endcase
               end
            end else if (param_ack) begin
               n.pend = 1'b0;
               n.st   = ST_BUILD;
               if (!param_ok) begin
                  // fault report in low value word
                  n.rsp  = `DST_RSP_FAIL;
                  n.rpwe = {24'h000000, param_fault};
               end else begin
                  case (q.param_id_word[15:12])
                     `DST_CMD_READ: begin
                        // width and sign from data type
                        if (is_wide(param_dtype)) begin
                           n.rsp  = `DST_RSP_DWORD;
                           n.rpwe = param_rdata;
                        end else begin
                           n.rsp  = `DST_RSP_WORD;
                           n.rpwe = {{16{param_rdata[15] && param_dtype == `DST_DT_I16}},
                                     param_rdata[15:0]};
                        end
                     end
                     `DST_CMD_WR_W, `DST_CMD_WR_WE: begin
                        n.rsp  = `DST_RSP_WORD;
                        n.rpwe = q.param_value_block;
                     end
                     `DST_CMD_WR_D, `DST_CMD_WR_DE: begin
                        n.rsp  = `DST_RSP_DWORD;
                        n.rpwe = q.param_value_block;
                     end
                     default: begin
                        // text read reply carries real length, at most 20 bytes
                        n.rsp = `DST_RSP_TEXT;
                        n.st  = ST_COPY;
                        if (q.subscript_word[15:8] == `DST_TXT_RD) begin
                           n.tn   = (text_len > `DST_TXT_MAX) ? `DST_TXT_MAX : text_len;
                           n.rlge = `DST_LGE_TXT
                                    + {3'b000, (text_len > `DST_TXT_MAX) ? `DST_TXT_MAX
                                                                         : text_len};
                        end else begin
                           // text length is telegram length minus ten
                           n.tn   = (q.length_byte >= `DST_LGE_TXT) ? 5'(q.length_byte - `DST_LGE_TXT) : 5'h00;
                           n.rlge = `DST_LGE_TXT;
                        end
                     end
                  endcase
               end
            end
         end

         ST_COPY: begin
            // one byte issued per cycle, handled the next
            n.pend = 1'b0;
            if (q.cp != q.tn) begin
               n.cp   = q.cp + 5'h01;
               n.cpp  = q.cp;
               n.pend = 1'b1;
               if (q.subscript_word[15:8] == `DST_TXT_RD) begin
                  n.taddr = q.cp;
               end else begin
                  b_addr = `DST_POS_TXT + q.cp;
               end
            end
            if (q.pend) begin
               if (q.subscript_word[15:8] == `DST_TXT_RD) begin
                  b_we   = 1'b1;
                  b_addr = `DST_POS_TXT + q.taddr;
                  b_wd   = text_rdata;
               end else begin
                  n.twe    = 1'b1;
                  n.twdata = b_rd;
                  n.taddr  = q.cpp;
               end
            end
            if (q.cp == q.tn && !q.pend) begin
               n.st   = ST_BUILD;
               n.bidx = 6'h00;
            end
         end

         ST_BUILD: begin
            b_addr = q.bidx[4:0];
            case (q.bidx)
               6'h00: rbyte = `DST_STX;
               6'h01: rbyte = q.rlge;
               6'h02: rbyte = q.adr;
               default: begin
                  if ({2'b00, q.bidx} >= q.rlge - `DST_PCD_SPAN) begin
                     off   = 6'({2'b00, q.bidx} - (q.rlge - `DST_PCD_SPAN));
                     rbyte = byte_of({status_word, out_freq}, off[1:0]);
                  end else if (q.bidx == `DST_POS_PKE_H) begin
                     rbyte = {q.rsp, q.param_id_word[11:8]};
                  end else if (q.bidx == `DST_POS_PKE_L) begin
                     rbyte = q.param_id_word[7:0];
                  end else if (q.bidx == `DST_POS_IND_H) begin
                     rbyte = q.subscript_word[15:8];
                  end else if (q.bidx == `DST_POS_IND_L) begin
                     rbyte = q.subscript_word[7:0];
                  end else begin
                     off   = q.bidx - `DST_POS_PWE;
                     rbyte = byte_of(q.rpwe, off[1:0]);
                  end
               end
            endcase
            // text bytes already sit in the buffer
            b_we = !(q.rsp == `DST_RSP_TEXT && q.subscript_word[15:8] == `DST_TXT_RD
                     && q.bidx >= {1'b0, `DST_POS_TXT}
                     && q.bidx < {1'b0, `DST_POS_TXT} + {1'b0, q.tn});
            b_wd = rbyte;
            n.bidx = q.bidx + 6'h01;
            if ({2'b00, q.bidx} == q.rlge) begin
               // bus driven only to answer this node
               n.st    = ST_TX;
               n.bidx  = 6'h00;
               n.xacc  = 8'h00;
               n.pend  = 1'b0;
            end
         end

         ST_TX: begin
            b_addr = q.bidx[4:0];
            n.pend = 1'b0;
            if (q.pend) begin
               n.tx_on  = 1'b1;
               n.tx_cnt = baud_div - 16'h0001;
               n.tx_bit = 4'h0;
               n.tx_sh  = {1'b1, par_of(b_rd), b_rd, 1'b0};
               n.tx_oe  = 1'b1;      // driver on with the first start bit
               n.txd    = 1'b0;
               n.xacc   = q.xacc ^ b_rd;
               n.bidx   = q.bidx + 6'h01;
            end else if (!q.tx_on) begin
               if ({2'b00, q.bidx} <= q.rlge) begin
                  n.pend = 1'b1;
               end else if ({2'b00, q.bidx} == q.rlge + 8'h01) begin
                  n.tx_on  = 1'b1;
                  n.tx_cnt = baud_div - 16'h0001;
                  n.tx_bit = 4'h0;
                  n.tx_sh  = {1'b1, par_of(q.xacc), q.xacc, 1'b0};
                  n.txd    = 1'b0;
                  n.bidx   = q.bidx + 6'h01;
               end else begin
                  n.tx_oe = 1'b0;
                  n.st    = ST_RX;
               end
            end
         end

         default: begin
            n.st = ST_RX;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register, line idles high
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q      <= '0;
         q.rx_m <= 1'b1;
         q.rx_s <= 1'b1;
         q.txd  <= 1'b1;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from registers
   assign txd                = q.txd;
   assign txd_oe             = q.tx_oe;
   assign param_req          = q.preq;
   assign param_command_code = q.param_id_word[15:12];
   assign param_number_field = q.param_id_word[11:0];
   assign param_sub          = q.subscript_word[7:0];
   assign param_wdata        = q.param_value_block;
   assign text_addr          = q.taddr;
   assign text_wdata         = q.twdata;
   assign text_we            = q.twe;
   assign ctrl_word          = q.ctrl;
   assign ref_value          = q.refv;
   assign pcd_stb            = q.pcd_stb;
   assign tg_ok              = q.tg_ok;
   assign tg_drop            = q.tg_drop;
endmodule : dst_slave
`default_nettype wire

// ---- verification/dst_slave_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dst_slave_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic txd,
   input wire logic txd_oe,
   input wire logic param_req,
   input wire logic pcd_stb,
   input wire logic tg_ok,
   input wire logic tg_drop
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // a reply opens with a held start bit; a dropped telegram stays mute
   sequence s_start; !txd [*2]; endsequence
   sequence s_mute; !txd_oe [*8]; endsequence
   idle_high_a: assert property (!txd_oe |-> txd) else $error("idle low");
   reply_open_a: assert property ($rose(txd_oe) |-> s_start) else $error("no start");
   reply_close_a: assert property ($fell(txd_oe) |-> $past(txd)) else $error("no stop");
   drop_mute_a: assert property (tg_drop |-> s_mute) else $error("drop sent");
   ok_drop_a: assert property (!(tg_ok && tg_drop)) else $error("ok and drop");
   req_pulse_a: assert property (param_req |=> !param_req) else $error("req long");
   req_cause_a: assert property ($rose(param_req) |-> $past(tg_ok)) else $error("req");
   pcd_good_a: assert property (pcd_stb |-> tg_ok && !txd_oe) else $error("pcd");
endmodule : dst_slave_sva
bind dst_slave dst_slave_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .txd(txd),
   .txd_oe(txd_oe), .param_req(param_req), .pcd_stb(pcd_stb), .tg_ok(tg_ok), .tg_drop(tg_drop));
`default_nettype wire

// ---- verification/dst_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dst_master_model (
   input wire logic ref_clk,
   input wire logic txd,
   input wire logic txd_oe,
   output logic     rxd
);
   localparam int BIT = 8; // equals baud_div in the bench
   logic [8:0] rx_q[$];
   initial rxd = 1'b1;
   task automatic send_char(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge ref_clk);
         #1 rxd = f[i];
         repeat (BIT - 1) @(posedge ref_clk);
      end
   endtask : send_char
   task automatic send_tg(input logic [7:0] a, input logic [7:0] d[$], input logic [7:0] flip);
      logic [7:0] t[$];
      logic [7:0] x;
      t = {8'h02, 8'(d.size() + 2), a, d};
      x = 8'h00;
      foreach (t[i]) x ^= t[i];
      t.push_back(x ^ flip);
      foreach (t[i]) send_char(t[i]);
   endtask : send_tg
   // mid-bit sampling of the reply, parity kept above the data
   always begin : rx_p
      logic [8:0] s;
      wait (txd_oe && !txd);
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge ref_clk);
         s[i] = txd;
      end
      rx_q.push_back(s);
      repeat (BIT) @(posedge ref_clk);
   end
endmodule : dst_master_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk = 0, rst_n = 0, param_ack = 0, param_ok = 0, ok_s, drop_s;
   logic rxd, txd, txd_oe, param_req, pcd_stb, tg_ok, tg_drop, text_we;
   logic [3:0] param_command_code;
   logic [4:0] text_addr, text_len = 5'h00;
   logic [6:0] node_addr = 7'h05;
   logic [7:0] param_sub, text_wdata, param_fault, param_dtype, text_rdata = 8'h00;
   logic [11:0] param_number_field;
   logic [15:0] baud_div = 16'h0008, ctrl_word, ref_value, status_word, out_freq;
   logic [31:0] param_wdata, param_rdata;
   logic [7:0] process_block[$] = '{8'h11, 8'h22, 8'h33, 8'h44}, st[$] = '{8'hEE, 8'hDD, 8'h33, 8'h44};
   logic [9:0] rows[6] = '{{8'h05, 2'b11}, {8'h45, 2'b11}, {8'h25, 2'b10},
                           {8'h06, 2'b00}, {8'h85, 2'b11}, {8'h80, 2'b10}};
   int failures = 0, total_checks = 0;
   // store side echoes the request so answers differ per parameter
   assign status_word = ~ctrl_word;
   assign out_freq = ref_value;
   assign param_fault = param_number_field[7:0];
   assign param_dtype = param_number_field[11:4];
   assign param_rdata = {20'h0, param_number_field};
   always #50 ref_clk = ~ref_clk;
   dst_slave dut (.*);
   dst_master_model m (.ref_clk(ref_clk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));
   // store answers in the same cycle as a request; 052 is refused
   always @(posedge ref_clk) begin
      #1 param_ack = param_req;
      param_ok = param_number_field !== 12'h052;
      if (tg_ok) ok_s = 1;
      if (tg_drop) drop_s = 1;
   end
   task automatic chk(input string nm, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic run(input logic [7:0] a, d[$], flip, input logic ok, rep, input logic [7:0] r[$]);
      logic [7:0] e[$];
      logic [7:0] x;
      e = {8'h02, 8'(r.size() + 2), a, r};
      x = 8'h00;
      foreach (e[i]) x ^= e[i];
      e.push_back(x);
      if (!rep) e = {};
      ok_s = 0;
      drop_s = 0;
      m.rx_q = {};
      m.send_tg(a, d, flip);
      for (int k = 0; k < 2000 && m.rx_q.size() < (rep ? e.size() : 1); k++) @(posedge ref_clk);
      repeat (30) @(posedge ref_clk);
      chk("tg_ok", ok, ok_s);
      chk("tg_drop", !ok, drop_s);
      chk("reply count", e.size(), m.rx_q.size());
      foreach (e[i]) chk("reply byte", {^e[i], e[i]}, m.rx_q[i]);
      chk("ctrl", 16'h1122, ctrl_word);
   endtask : run
   initial begin
      #10_000_000 failures++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 rst_n = 1;
      repeat (3) @(posedge ref_clk);
      foreach (rows[i]) run(rows[i][9:2], process_block, 0, rows[i][1], rows[i][0], st);
      run(8'h05, process_block, 8'h01, 0, 0, st);
      run(8'h85, {8'h11, 8'h55, 0, 0, 0, 0, 0, 0, process_block}, 0, 1, 1,
          {8'h11, 8'h55, 0, 0, 0, 0, 8'h01, 8'h55, st});
      chk("pnu", 12'h155, param_number_field);
      run(8'h85, {8'h21, 0, 8'h12, 8'h34, 0, 0, 8'h0A, 8'hBC, process_block}, 0, 1, 1,
          {8'h11, 0, 8'h12, 8'h34, 0, 0, 8'h0A, 8'hBC, st});
      chk("cmd", 4'h2, param_command_code);
      chk("sub", 8'h34, param_sub);
      run(8'h85, {8'h10, 8'h52, 0, 0, 0, 0, 0, 0, process_block}, 0, 1, 1,
          {8'h70, 8'h52, 0, 0, 0, 0, 0, 8'h52, st});
      run(8'h85, {8'h40, 8'h10, 0, 0, 0, 0, 0, 0, process_block}, 0, 1, 1,
          {8'h70, 8'h10, 0, 0, 0, 0, 0, 0, st});
      run(8'h85, {8'h31, 0, 0, 0, 8'hDE, 8'hAD, 8'hBE, 8'hEF, process_block}, 0, 1, 1,
          {8'h21, 0, 0, 0, 8'hDE, 8'hAD, 8'hBE, 8'hEF, st});
      run(8'h85, {8'hF0, 8'h28, 8'h04, 0, process_block}, 0, 1, 1, {8'hF0, 8'h28, 8'h04, 0, st});
      end_of_test();
   end
endmodule : tb
`default_nettype wire
